// *** logic/clk_rst_pkg.sv ***
// constants shared by the reset and clock source selection block
// assumes a single 20 MHz system clock and an 8-bit register port
package clk_rst_pkg;
  localparam int unsigned CLK_MHZ          = 20;                // system clock rate
  localparam int unsigned RST_PULSE_NS     = 500;               // least reset pin low time
  localparam int unsigned RST_PULSE_CYC    = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOST_QUIET_US    = 500;               // host quiet time after reset
  localparam int unsigned HOST_QUIET_CYC   = HOST_QUIET_US * CLK_MHZ;
  localparam int unsigned AW               = 8;                 // register address width
  localparam int unsigned DW               = 8;                 // register data width
  // register offsets
  localparam logic [7:0] ADDR_CTRL         = 8'h01;             // reset and power-down
  localparam logic [7:0] ADDR_PORT_A       = 8'h03;             // serial port a clocking
  localparam logic [7:0] ADDR_PORT_B       = 8'h05;             // serial port b clocking
  localparam logic [7:0] ADDR_TX           = 8'h07;             // transmitter clocking
  localparam logic [7:0] ADDR_RX           = 8'h08;             // receiver reference select
  localparam logic [7:0] ADDR_STATUS       = 8'h09;             // read-only state
  // control register fields
  localparam int unsigned CTRL_RESET_BIT   = 7;                 // write one: soft reset
  localparam int unsigned PWR_PORT_A       = 0;                 // one: block running
  localparam int unsigned PWR_PORT_B       = 1;
  localparam int unsigned PWR_TX           = 2;
  localparam int unsigned PWR_RX           = 3;
  localparam logic [3:0] PWR_RESET         = 4'h0;              // all blocks powered down
  // port config fields: bit0 master, bits2:1 source, bits4:3 ratio
  localparam int unsigned CFG_MASTER_BIT   = 0;
  localparam int unsigned CFG_SRC_LO       = 1;
  localparam int unsigned CFG_RATIO_LO     = 3;
  // transmitter config fields: bit0 source, bits2:1 ratio
  localparam int unsigned TX_SRC_BIT       = 0;
  localparam int unsigned TX_RATIO_LO      = 1;
  // clock sources as indices of the edge vector
  localparam logic [1:0] SRC_MCLK          = 2'h0;
  localparam logic [1:0] SRC_REFIN         = 2'h1;
  localparam logic [1:0] SRC_RECOV         = 2'h2;
  // divider geometry: lrck half period is 64 source edges per ratio step
  localparam logic [8:0] LRCK_HALF_STEP    = 9'h040;
  localparam logic [7:0] REG_RESET         = 8'h00;
endpackage : clk_rst_pkg

// *** logic/clk_rst_ctrl.sv ***
// reset handling, power-down control and master clock source selection
// assumes clock pins are far slower than clk and arrive unsynchronised
module clk_rst_ctrl
  import clk_rst_pkg::*;
(
  input  wire logic                       clk,                    // 20 MHz system clock
  input  wire logic                       rst,                    // synchronous, active high
  input  wire logic                       chip_reset_n,           // asynchronous reset pin
  input  wire logic                       mclk_pin,               // main master clock input
  input  wire logic                       receiver_ref_clock_in,  // receiver reference clock pin
  input  wire logic                       recovered_clock_raw,    // clock from receiver core
  input  wire logic [clk_rst_pkg::AW-1:0] reg_addr,
  input  wire logic [clk_rst_pkg::DW-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [clk_rst_pkg::DW-1:0] reg_rdata,
  input  wire logic                       port_a_lrck_in,
  output logic                            port_a_lrck_out,
  output logic                            port_a_lrck_oe,
  input  wire logic                       port_a_bck_in,
  output logic                            port_a_bck_out,
  output logic                            port_a_bck_oe,
  input  wire logic                       port_b_lrck_in,
  output logic                            port_b_lrck_out,
  output logic                            port_b_lrck_oe,
  input  wire logic                       port_b_bck_in,
  output logic                            port_b_bck_out,
  output logic                            port_b_bck_oe,
  output logic                            tx_frame_tick,          // one pulse per frame
  output logic                            rx_ref_tick,            // receiver reference edge
  output logic                            recovered_clock_out,
  output logic      [3:0]                 block_run                // per-block power state
);
  import clk_rst_pkg::*;

  // how the block works, in brief:
  // - three reset causes meet in rst_int: the rst input, the pin reset
  //   after its release synchroniser, and the one-cycle soft reset pulse
  // - every reset cause clears the whole state at once, so no setting
  //   survives a reset and every block comes back powered down
  // - the clock pins are not clocks inside this block; they are sampled
  //   by clk and turned into one-cycle edge enables
  // - this limits the usable source rate to well below half of clk; a
  //   faster master clock would alias and drop edges
  // - each divider counts edges of its own selected source and makes
  //   the word clock, the bit clock and a frame wrap pulse
  // - source and ratio settings reach a running divider only at a frame
  //   wrap, so a change never shortens a word clock half period
  // - a stopped divider follows its settings at once, since its outputs
  //   are held low and nothing downstream can see a runt pulse
  // - a serial port in slave mode leaves its divider stopped; its clock
  //   pins are then inputs and only their levels are reported
  // - the transmitter can never pick the reference pin, because its
  //   source field has only one bit
  // - the receiver path only forwards edges and levels; the lock loop
  //   itself lives outside this block
  // - all outputs come from the state register, so nothing combinational
  //   reaches a pin
  // - the register port never stalls: writes land at the next edge and
  //   read data stand for exactly one cycle after the strobe

  // one clock divider: latched source and ratio, edge and bit counters
  typedef struct packed {
    logic [1:0] src;      // source in use, changed only at frame wrap or while stopped
    logic [1:0] ratio;    // 0..3 selects 128, 256, 384, 512
    logic [8:0] cnt;      // source edges within one frame
    logic [2:0] bcnt;     // source edges within one bit clock
    logic       lrck;
    logic       bck;
    logic       wrap;     // frame boundary seen this cycle
  } div_t;

  typedef struct packed {
    logic [7:0]    ctrl;     // power bits
    logic [7:0]    cfg_a;
    logic [7:0]    cfg_b;
    logic [7:0]    cfg_tx;
    logic [7:0]    cfg_rx;
    logic [7:0]    rdata;
    logic          soft_rst; // one cycle of internal reset after the bit write
    logic [2:0]    prev;     // last synchronised level of each source
    div_t [2:0]    div;      // port a, port b, transmitter
    logic          rx_tick;
    logic          recov;
    logic [3:0]    slave_lvl; // synchronised slave clock levels
  } state_t;

  // divider reset value: idle low outputs, counters cleared
  localparam div_t DIV_RESET = '{src: SRC_MCLK, ratio: 2'h0, cnt: 9'h000, bcnt: 3'h0,
                                 lrck: 1'b0, bck: 1'b0, wrap: 1'b0};

  state_t s_reg;   // all registers
  state_t s_next;  // their next value

  logic [1:0] rst_sync;       // release synchroniser for the reset pin
  logic [2:0] src_meta;       // first stage of clock pin synchronisers
  logic [2:0] src_sync;       // second stage, the only stage logic reads
  logic [3:0] slv_meta;       // first stage for slave clock inputs
  logic [3:0] slv_sync;
  logic       rst_int;        // combined reset seen by the state
  logic [2:0] edges;          // one-cycle enables, one per source

  // reset pin asserts at once but releases on clk; only constants under async reset
  always_ff @(posedge clk or negedge chip_reset_n)
  begin
    if (!chip_reset_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // two flip-flops before any logic touches a pin
  always_ff @(posedge clk)
  begin
    src_meta <= {recovered_clock_raw, receiver_ref_clock_in, mclk_pin};
    src_sync <= src_meta;
    slv_meta <= {port_b_bck_in, port_b_lrck_in, port_a_bck_in, port_a_lrck_in};
    slv_sync <= slv_meta;
  end

  assign rst_int = rst | ~rst_sync[1] | s_reg.soft_rst;
  assign edges   = src_sync & ~s_reg.prev;                // rising edge enables

  // advance one divider by a source edge; new settings load only at the frame wrap or while stopped
  // the frame is 2 * 64 * (ratio + 1) source edges long; the bit counter
  // runs 64 times per frame, so one bit clock lasts 2 * (ratio + 1) edges
  // the ratio is widened before the plus one: in two bits the largest
  // ratio would wrap to zero and give an empty frame
  function automatic div_t div_step(input div_t d, input logic run, input logic edge_en,
                                    input logic [1:0] new_src, input logic [1:0] new_ratio);
    div_t       n;
    logic [8:0] half;
    logic [8:0] last;
    n      = d;
    n.wrap = 1'b0;
    half   = LRCK_HALF_STEP * ({7'h00, d.ratio} + 9'h001);
    last   = 9'((half << 1) - 9'h001);
    if (!run)
    begin
      n       = DIV_RESET;                // stopped block holds outputs low
      n.src   = new_src;
      n.ratio = new_ratio;
    end
    else if (edge_en)
    begin
      if (d.cnt == last)
      begin
        n.cnt   = 9'h000;
        n.bcnt  = 3'h0;
        n.wrap  = 1'b1;
        n.src   = new_src;
        n.ratio = new_ratio;
      end
      else
      begin
        n.cnt  = d.cnt + 9'h001;
        n.bcnt = (d.bcnt == {d.ratio, 1'b1}) ? 3'h0 : d.bcnt + 3'h1;
      end
      n.lrck = (n.cnt >= half);
      n.bck  = (n.bcnt > {1'b0, d.ratio});  // bit clock is 64 times word clock
    end
    return n;
  endfunction : div_step

  // next-state logic: register port, power control, dividers
  // read data default to zero, so the read port shows a value for exactly
  // one cycle after the strobe and idles low otherwise
  // a soft reset write still loads the run bits here, but the reset pulse
  // of the next cycle clears them again before any block can start
  // the edge history is refreshed every cycle, so an edge enable never
  // lasts more than one cycle whatever the source rate
  always_comb
  begin
    s_next           = s_reg;
    s_next.soft_rst  = 1'b0;
    s_next.prev      = src_sync;
    s_next.slave_lvl = slv_sync;
    s_next.rdata     = REG_RESET;
    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CTRL:
        begin
          s_next.ctrl     = {4'h0, reg_wdata[3:0]};
          s_next.soft_rst = reg_wdata[CTRL_RESET_BIT];
        end
        ADDR_PORT_A: s_next.cfg_a  = {3'h0, reg_wdata[4:0]};
        ADDR_PORT_B: s_next.cfg_b  = {3'h0, reg_wdata[4:0]};
        ADDR_TX:     s_next.cfg_tx = {5'h00, reg_wdata[2:0]};
        ADDR_RX:     s_next.cfg_rx = {7'h00, reg_wdata[0]};
        default:     s_next.ctrl   = s_reg.ctrl;     // unmapped writes ignored
      endcase
    end
    // register reads, answered in the next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
        ADDR_PORT_A: s_next.rdata = s_reg.cfg_a;
        ADDR_PORT_B: s_next.rdata = s_reg.cfg_b;
        ADDR_TX:     s_next.rdata = s_reg.cfg_tx;
        ADDR_RX:     s_next.rdata = s_reg.cfg_rx;
        // status: slave pin levels, transmitter on the recovered clock, word clocks
        ADDR_STATUS: s_next.rdata = {s_reg.slave_lvl, s_reg.div[2].src[1], s_reg.div[2].lrck,
                                     s_reg.div[1].lrck, s_reg.div[0].lrck};
        default:     s_next.rdata = REG_RESET;        // unmapped reads zero
      endcase
    end
    // serial ports run only when powered and in master mode
    s_next.div[0] = div_step(s_reg.div[0],
                             s_reg.ctrl[PWR_PORT_A] & s_reg.cfg_a[CFG_MASTER_BIT],
                             edges[s_reg.div[0].src],
                             s_reg.cfg_a[CFG_SRC_LO +: 2] == 2'h3 ? SRC_MCLK
                                                                  : s_reg.cfg_a[CFG_SRC_LO +: 2],
                             s_reg.cfg_a[CFG_RATIO_LO +: 2]);
    s_next.div[1] = div_step(s_reg.div[1],
                             s_reg.ctrl[PWR_PORT_B] & s_reg.cfg_b[CFG_MASTER_BIT],
                             edges[s_reg.div[1].src],
                             s_reg.cfg_b[CFG_SRC_LO +: 2] == 2'h3 ? SRC_MCLK
                                                                  : s_reg.cfg_b[CFG_SRC_LO +: 2],
                             s_reg.cfg_b[CFG_RATIO_LO +: 2]);
    // transmitter: main clock or recovered clock only, never the reference pin
    s_next.div[2] = div_step(s_reg.div[2], s_reg.ctrl[PWR_TX], edges[s_reg.div[2].src],
                             s_reg.cfg_tx[TX_SRC_BIT] ? SRC_RECOV : SRC_MCLK,
                             s_reg.cfg_tx[TX_RATIO_LO +: 2]);
    // receiver reference edge from the selected input while the receiver runs
    s_next.rx_tick = s_reg.ctrl[PWR_RX] & (s_reg.cfg_rx[0] ? edges[SRC_REFIN]
                                                          : edges[SRC_MCLK]);
    // recovered clock forwarded only while the receiver is released
    s_next.recov = s_reg.ctrl[PWR_RX] & src_sync[SRC_RECOV];
  end

  // single state register; reset clears every setting and powers blocks down
  // the dividers are reset to their own idle value, which keeps the
  // source field on the main clock after any reset
  // rst_int is only released in step with clk, so this stays a plain
  // synchronous reset; only the release flip-flops see the pin directly
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      s_reg        <= '0;
      s_reg.ctrl   <= {4'h0, PWR_RESET};
      s_reg.div[0] <= DIV_RESET;
      s_reg.div[1] <= DIV_RESET;
      s_reg.div[2] <= DIV_RESET;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  // output enables follow the master bit alone: a master port that is
  // powered down still drives its pins, low, rather than floating them
  // a slave port never drives, whatever its power bit says
  assign reg_rdata           = s_reg.rdata;
  assign port_a_lrck_out     = s_reg.div[0].lrck;
  assign port_a_bck_out      = s_reg.div[0].bck;
  assign port_a_lrck_oe      = s_reg.cfg_a[CFG_MASTER_BIT];   // slave: pin is an input
  assign port_a_bck_oe       = s_reg.cfg_a[CFG_MASTER_BIT];
  assign port_b_lrck_out     = s_reg.div[1].lrck;
  assign port_b_bck_out      = s_reg.div[1].bck;
  assign port_b_lrck_oe      = s_reg.cfg_b[CFG_MASTER_BIT];
  assign port_b_bck_oe       = s_reg.cfg_b[CFG_MASTER_BIT];
  assign tx_frame_tick       = s_reg.div[2].wrap;
  assign rx_ref_tick         = s_reg.rx_tick;
  assign recovered_clock_out = s_reg.recov;
  assign block_run           = s_reg.ctrl[3:0];
endmodule : clk_rst_ctrl

// *** tb/clock_sources.sv ***
// far-side clock sources: main, reference and recovered master clocks
// assumes the block samples them with a much faster system clock
module clock_sources
#(
  parameter int MCLK_HALF = 100,  // half periods in ns
  parameter int REF_HALF  = 150,
  parameter int REC_HALF  = 200
)
(
  output logic mclk_pin,
  output logic receiver_ref_clock_in,
  output logic recovered_clock_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  // master clocks run free, so they never stand still between frames
  initial
  begin
    {mclk_pin, receiver_ref_clock_in, recovered_clock_raw} = 3'h0;
    #13;
    fork
      forever #(MCLK_HALF) mclk_pin = ~mclk_pin;
      forever #(REF_HALF) receiver_ref_clock_in = ~receiver_ref_clock_in;
      forever #(REC_HALF) recovered_clock_raw = ~recovered_clock_raw;
    join
  end
endmodule : clock_sources

// *** tb/clk_rst_checker.sv ***
// assertions on the reset and clock selection block
// assumes it is bound to the block and sees only its ports
module clk_rst_checker
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       port_a_lrck_out,
  input wire logic       port_a_lrck_oe,
  input wire logic       port_a_bck_oe,
  input wire logic       tx_frame_tick,
  input wire logic       recovered_clock_out,
  input wire logic [3:0] block_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !chip_reset_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  run_write_a: assert property (reg_wr && reg_addr == 8'h01 && !reg_wdata[7] |=>
    block_run == $past(reg_wdata[3:0])) else $error("run bits not taken");
  soft_reset_a: assert property (reg_wr && reg_addr == 8'h01 && reg_wdata[7] |->
    ##[1:2] (block_run == 4'h0 && !port_a_lrck_oe)) else $error("soft reset missed");
  rst_clear_a: assert property (disable iff (1'b0) rst |=>
    (block_run == 4'h0 && reg_rdata == 8'h00)) else $error("reset left state");
  pin_clear_a: assert property (disable iff (rst) !chip_reset_n |=>
    (block_run == 4'h0 && !tx_frame_tick)) else $error("pin reset left state");
  oe_pair_a: assert property (port_a_lrck_oe == port_a_bck_oe) else $error("enables differ");
  oe_write_a: assert property (reg_wr && reg_addr == 8'h03 |=>
    port_a_lrck_oe == $past(reg_wdata[0])) else $error("master bit not taken");
  tick_single_a: assert property (tx_frame_tick |=> !tx_frame_tick) else $error("tick too long");
  tx_idle_a: assert property (!block_run[2] && !$past(block_run[2]) |->
    !tx_frame_tick) else $error("tick while stopped");
  lrck_hold_a: assert property (disable iff (rst || !chip_reset_n || reg_wr)
    $rose(port_a_lrck_out) |=> port_a_lrck_out [*8]) else $error("runt word clock");
  recov_gate_a: assert property (!block_run[3] && !$past(block_run[3]) |->
    !recovered_clock_out) else $error("recovered clock while stopped");
  cover property (tx_frame_tick);
  cover property ($rose(port_a_lrck_out));
  cover property (reg_wr && reg_addr == 8'h01 && reg_wdata[7]);
endmodule : clk_rst_checker

bind clk_rst_ctrl clk_rst_checker u_clk_rst_checker (.*);

// *** tb/testbench.sv ***
// self-checking bench for the reset and clock selection block
// assumes the source model drives the three clock pins
module testbench
  import clk_rst_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk = 1'b0;
  logic          rst = 1'b1;           // held 16 cycles
  logic          chip_reset_n = 1'b1;  // reset pin, active low
  logic [AW-1:0] reg_addr = 8'h00;
  logic [DW-1:0] reg_wdata = 8'h00, reg_rdata;
  logic          reg_wr = 1'b0, reg_rd = 1'b0;
  logic          mclk_pin, receiver_ref_clock_in, recovered_clock_raw;
  logic [3:0]    slv = 4'h0;           // slave clock pins from an outside master
  logic          port_a_lrck_out, port_a_lrck_oe, port_b_lrck_oe, tx_frame_tick;
  logic [3:0]    block_run;
  logic          rx_tick, recov_out;   // receiver reference pulses, forwarded clock
  logic [31:0]   seed = 32'hc543;      // xorshift state
  int            error_cnt = 0, n_checks = 0, cyc = 0;
  int            per [3] = '{4, 6, 8}; // source periods in clk cycles
  clock_sources u_clock_sources (.mclk_pin, .receiver_ref_clock_in, .recovered_clock_raw);
  clk_rst_ctrl u_clk_rst_ctrl (.clk, .rst, .chip_reset_n, .mclk_pin, .receiver_ref_clock_in,
    .recovered_clock_raw, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_a_lrck_in(slv[0]), .port_a_lrck_out, .port_a_lrck_oe, .port_a_bck_in(slv[1]),
    .port_a_bck_out(), .port_a_bck_oe(), .port_b_lrck_in(slv[2]), .port_b_lrck_out(),
    .port_b_lrck_oe, .port_b_bck_in(slv[3]), .port_b_bck_out(), .port_b_bck_oe(),
    .tx_frame_tick, .rx_ref_tick(rx_tick), .recovered_clock_out(recov_out), .block_run);
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // cycle count, slave pin activity and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    slv <= cyc[7:4];
    if (cyc == 100000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task give_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // tolerance covers one cycle of edge-synchroniser jitter
  task check(string what, logic [31:0] exp, logic [31:0] got, int tol);
    n_checks++;
    if (got !== exp && (tol == 0 || got > exp + tol || got + tol < exp))
    begin
      $display("BAD %s expected %0h seen %0h", what, exp, got);
      error_cnt++;
    end
  endtask : check
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // period between the second and third rise, skipping the reload at wrap
  task period(int sel, output int p);
    int k, t;
    logic prv, cur;
    k = 0;
    p = 0;
    prv = 1'b1;
    repeat (30000)
      if (k < 3)
      begin
        @(negedge clk);
        cur = (sel == 0) ? port_a_lrck_out : tx_frame_tick;
        if (cur && !prv)
          k++;
        if (cur && !prv && k == 2)
          t = cyc;
        if (cur && !prv && k == 3)
          p = cyc - t;
        prv = cur;
      end
  endtask : period
  initial
  begin
    logic [7:0] d;
    int p, sa, st, rs, nt, nr;
    logic pr;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("run", 4'h0, block_run, 0);
    rd(ADDR_CTRL, d);
    check("ctrl", 8'h00, d, 0);
    rd(8'h02, d);
    check("unmapped", 8'h00, d, 0);
    wr(ADDR_PORT_B, 8'h00);
    @(negedge clk);
    check("oe_b", 1'b0, port_b_lrck_oe, 0);
    wr(ADDR_CTRL, 8'h0f);
    @(negedge clk);
    check("run", 4'hf, block_run, 0);
    for (int r = 0; r < 4; r++)
    begin
      sa = xs() % 3;
      st = xs() % 2;
      rs = int'(xs() & 32'h1);
      wr(ADDR_RX, 8'(rs));
      wr(ADDR_PORT_A, 8'({r[1:0], sa[1:0], 1'b1}));
      wr(ADDR_TX, 8'({r[1:0], st[0]}));
      period(0, p);
      check("lrck_a", 128 * (r + 1) * per[sa], p, 1);
      period(1, p);
      check("tx_frame", 128 * (r + 1) * per[2 * st], p, 1);
    end
    // receiver reference pulses and forwarded recovered clock over a window
    nt = 0;
    nr = 0;
    pr = 1'b1;
    repeat (480)
    begin
      @(negedge clk);
      nt += int'(rx_tick);
      nr += int'(recov_out && !pr);
      pr = recov_out;
    end
    check("rx_tick", 480 / per[rs], nt, 1);
    check("recov", 480 / per[2], nr, 1);
    // slave pin levels, read while the driven levels are settled
    @(posedge clk iff cyc[3:0] == 4'h4);
    rd(ADDR_STATUS, d);
    check("slave_lvl", slv, d[7:4], 0);
    wr(ADDR_CTRL, 8'h8f);
    repeat (2) @(negedge clk);
    check("soft_run", 4'h0, block_run, 0);
    check("soft_oe", 1'b0, port_a_lrck_oe, 0);
    wr(ADDR_CTRL, 8'h0f);
    chip_reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("pin_run", 4'h0, block_run, 0);
    @(posedge clk);
    chip_reset_n <= 1'b1;
    repeat (HOST_QUIET_CYC) @(posedge clk);
    rd(ADDR_CTRL, d);
    check("pin_ctrl", 8'h00, d, 0);
    give_verdict();
  end
endmodule : testbench
